// *** logic/burst_sram_pkg.sv ***
// shared constants and types for the pipelined burst memory port
package burst_sram_pkg;
  // =========================================================
  // geometry
  localparam int unsigned DATA_W_DEF  = 32;
  localparam int unsigned LANES_DEF   = 4;
  localparam int unsigned ADDR_W_DEF  = 19;
  localparam int unsigned BURST_W     = 2;
  // =========================================================
  // values after reset
  localparam logic        SLEEP_RST   = 1'b0;
  localparam logic [1:0]  CNT_RST     = 2'h0;
  // =========================================================
  // timing: sleep entry / exit times, in ns, and exit cycles at 200 MHz
  localparam int unsigned CLK_PERIOD_PS      = 5000;
  localparam int unsigned SLEEP_ENTRY_TIME_NS = 10;
  localparam int unsigned SLEEP_EXIT_TIME_NS  = 10;
  localparam int unsigned SLEEP_EXIT_CYC =
    (SLEEP_EXIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // =========================================================
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } op_type;
endpackage

// *** logic/burst_seq_if.sv ***
// burst counter hand-off between the port logic and the address sequencer
`timescale 1ns/1ps
interface burst_seq_if;
  logic       load;
  logic       step;
  logic [1:0] start;
  logic       interleave;
  logic [1:0] low_bits;
  modport ctrl (output load, output step, output start, output interleave, input low_bits);
  modport seq  (input load, input step, input start, input interleave, output low_bits);
endinterface

// *** logic/burst_addr_seq.sv ***
// two-bit burst address sequencer, interleaved or linear
`timescale 1ns/1ps
module burst_addr_seq (
  // clock and reset
  input wire logic   mclk,
  input wire logic   rst_b,
  // sequencer side of the hand-off
  burst_seq_if.seq   bus
);
  // =========================================================
  // counter
  logic [1:0] start_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;

  assign cnt_nxt = bus.load ? burst_sram_pkg::CNT_RST :
                   bus.step ? cnt_r + 2'h1 : cnt_r;
  // interleave xors the count in, linear adds it and wraps
  assign bus.low_bits = bus.interleave ? (start_r ^ cnt_r)
                                       : (start_r + cnt_r);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r   <= burst_sram_pkg::CNT_RST;
      start_r <= burst_sram_pkg::CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
      if (bus.load) begin
        start_r <= bus.start;
      end
    end
  end

  // first interleaved step flips only the lowest bit
  a_interleave_seq : assert property (@(posedge mclk) disable iff (!rst_b)
    (bus.interleave && bus.step && !bus.load && cnt_r == 2'h0) ##1 bus.interleave
      |-> bus.low_bits == {$past(bus.low_bits[1]), !$past(bus.low_bits[0])})
    else $error("interleaved burst bits wrong");
  a_linear_step : assert property (@(posedge mclk) disable iff (!rst_b)
    (bus.step && !bus.load && !bus.interleave) ##1 !bus.interleave
      |-> bus.low_bits == $past(bus.low_bits) + 2'h1)
    else $error("linear burst did not step by one");
endmodule // burst_addr_seq

// *** logic/burst_sram_port.sv ***
// pipelined burst static memory port: strobes, selects, bursts, writes, sleep
`timescale 1ns/1ps
module burst_sram_port #(
  parameter int unsigned DATA_W = burst_sram_pkg::DATA_W_DEF,
  parameter int unsigned LANES  = burst_sram_pkg::LANES_DEF,
  parameter int unsigned ADDR_W = burst_sram_pkg::ADDR_W_DEF
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // address and selects
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              master_select_n,
  input  wire logic              secondary_select_high,
  input  wire logic              secondary_select_low_n,
  input  wire logic              proc_addr_strobe_n,
  input  wire logic              ctrl_addr_strobe_n,
  input  wire logic              burst_advance_n,
  // writes
  input  wire logic              global_write_n,
  input  wire logic              byte_write_gate_n,
  input  wire logic [LANES-1:0]  lane_write_n,
  // static and unclocked controls; sleep_request is sampled on mclk
  input  wire logic              output_enable_n,
  input  wire logic              burst_order_select,
  input  wire logic              sleep_request,
  // data pins, split
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic      [DATA_W-1:0] data_oe_n,
  // status
  output logic                   sleep_state
);
  localparam int unsigned LANE_W = DATA_W / LANES;
  localparam int unsigned DEPTH  = 1 << ADDR_W;

  initial begin
    if (LANES == 0 || DATA_W % LANES != 0 || ADDR_W < burst_sram_pkg::BURST_W) begin
      $error("burst_sram_port: bad width parameters");
    end
  end

  // =========================================================
  // storage and state
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] addr_r;
  logic              active_r;
  logic              wr_burst_r;
  logic              read_r;
  logic [DATA_W-1:0] rdata_r;
  logic              sleep_r;
  logic [DATA_W-1:0] oe_n_r;

  burst_seq_if seq ();

  burst_addr_seq u_seq (
    .mclk  (mclk),
    .rst_b (rst_b),
    .bus   (seq)
  );

  // =========================================================
  // strobe and select decode
  wire logic proc_strobe  = !proc_addr_strobe_n && !master_select_n;
  wire logic ctrl_strobe  = !ctrl_addr_strobe_n && proc_addr_strobe_n;
  wire logic any_strobe   = (proc_strobe || ctrl_strobe) && !sleep_r;
  wire logic selects_on   = !master_select_n && secondary_select_high
                            && !secondary_select_low_n;
  wire logic start_cycle  = any_strobe && selects_on;
  wire logic deselect     = any_strobe && !selects_on;
  wire logic no_strobe    = proc_addr_strobe_n && ctrl_addr_strobe_n;
  wire logic advance      = !sleep_r && active_r && no_strobe
                            && !burst_advance_n;

  // write decode; processor strobe cycles start as reads
  wire logic [LANES-1:0] lane_wr = !global_write_n ? {LANES{1'b1}}
                         : (!byte_write_gate_n ? ~lane_write_n
                                               : {LANES{1'b0}});
  wire logic             wr_any  = |lane_wr;
  wire logic             wr_now  = !proc_strobe && !sleep_r && active_r
                                   && !start_cycle && wr_any;
  wire logic             ctrl_wr = ctrl_strobe && start_cycle && wr_any;
  wire logic [ADDR_W-1:0] cur_addr = {addr_r[ADDR_W-1:2], seq.low_bits};

  assign seq.load       = start_cycle;
  assign seq.step       = advance;
  assign seq.start      = addr[1:0];
  assign seq.interleave = burst_order_select;

  // a read needs output enable, the chip in read and no sleep
  wire logic drive_now = read_r && !output_enable_n && !sleep_r;

  // =========================================================
  // address, cycle and sleep registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      addr_r     <= '0;
      active_r   <= 1'b0;
      wr_burst_r <= 1'b0;
      sleep_r    <= burst_sram_pkg::SLEEP_RST;
    end else begin
      sleep_r <= sleep_request;
      if (sleep_request || deselect) begin
        active_r <= 1'b0;
      end else if (start_cycle) begin
        addr_r     <= addr;
        active_r   <= 1'b1;
        wr_burst_r <= ctrl_wr;
      end else if (wr_now) begin
        wr_burst_r <= 1'b1;
      end
    end
  end

  // =========================================================
  // array: writes land per lane, reads registered once
  always_ff @(posedge mclk) begin
    for (int i = 0; i < LANES; i++) begin
      if ((ctrl_wr || wr_now) && lane_wr[i]) begin
        mem[ctrl_wr ? addr : cur_addr][i*LANE_W +: LANE_W] <= data_in[i*LANE_W +: LANE_W];
      end
    end
  end

  // data registered on the same edge as the address, driven from the edge after
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      read_r  <= 1'b0;
      rdata_r <= '0;
    end else begin
      read_r  <= active_r && !sleep_request && !deselect && !wr_now
                 && !ctrl_wr && !(wr_burst_r && !start_cycle);
      rdata_r <= mem[start_cycle ? addr : cur_addr];
    end
  end

  // output enable flopped, then data_oe_n gated live by output_enable_n through drive_now
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      oe_n_r <= '1;
    end else begin
      oe_n_r <= {DATA_W{!(active_r && !output_enable_n && !sleep_request
                          && !deselect && !wr_now && !ctrl_wr)}};
    end
  end

  assign data_out    = rdata_r;
  assign data_oe_n   = oe_n_r | {DATA_W{!drive_now}};
  assign sleep_state = sleep_r;

  // =========================================================
  a_sleep_floats : assert property (@(posedge mclk) disable iff (!rst_b)
    sleep_r |-> data_oe_n == '1)
    else $error("data driven in sleep");
  a_deselect_floats : assert property (@(posedge mclk) disable iff (!rst_b)
    deselect |=> !active_r ##0 data_oe_n == '1)
    else $error("deselect left outputs on");
  a_addr_captured : assert property (@(posedge mclk) disable iff (!rst_b)
    start_cycle && !sleep_request |=> addr_r == $past(addr))
    else $error("address not captured");
  // a blocked processor strobe must leave the held address alone
  a_master_blocks : assert property (@(posedge mclk) disable iff (!rst_b)
    master_select_n && !proc_addr_strobe_n && ctrl_addr_strobe_n
      |=> addr_r == $past(addr_r))
    else $error("processor strobe not blocked");
  a_read_pipe : assert property (@(posedge mclk) disable iff (!rst_b)
    start_cycle && !ctrl_wr && !sleep_request ##1 !sleep_request && !deselect
      && !wr_now && !ctrl_wr |=> read_r)
    else $error("read not in pipeline");
  a_proc_no_write : assert property (@(posedge mclk) disable iff (!rst_b)
    proc_strobe |-> !wr_now && !ctrl_wr)
    else $error("lane write taken on processor strobe");
  a_global_all : assert property (@(posedge mclk) disable iff (!rst_b)
    !global_write_n |-> lane_wr == {LANES{1'b1}})
    else $error("global write missed lanes");
  a_oe_gates : assert property (@(posedge mclk) disable iff (!rst_b)
    output_enable_n || !read_r |-> data_oe_n == '1)
    else $error("driven without read and enable");
  a_advance_proc : assert property (@(posedge mclk) disable iff (!rst_b)
    !proc_addr_strobe_n |-> !seq.step)
    else $error("advance on processor strobe");

  // =========================================================
  // array contents and cycle state after the edge
  a_global_lands : assert property (@(posedge mclk) disable iff (!rst_b)
    ctrl_wr && !global_write_n |=> mem[$past(addr)] == $past(data_in))
    else $error("global write did not land");
  a_lane_lands : assert property (@(posedge mclk) disable iff (!rst_b)
    wr_now && lane_wr[0]
      |=> mem[$past(cur_addr)][LANE_W-1:0] == $past(data_in[LANE_W-1:0]))
    else $error("lane write did not land");
  a_sleep_idle : assert property (@(posedge mclk) disable iff (!rst_b)
    sleep_request |=> !active_r && !read_r)
    else $error("cycle kept through sleep");
  a_deselect_idle : assert property (@(posedge mclk) disable iff (!rst_b)
    deselect |=> !read_r)
    else $error("read kept after deselect");
  a_start_active : assert property (@(posedge mclk) disable iff (!rst_b)
    start_cycle && !sleep_request |=> active_r)
    else $error("strobe did not start a cycle");
endmodule // burst_sram_port

// *** dv/bus_host_model.sv ***
// far-side bus model: resolves the shared data lines, flags contention
`timescale 1ns/1ps
module bus_host_model (
  // clock
  input  wire logic        mclk,
  // memory side of the data lines
  input  wire logic [31:0] dev_out,
  input  wire logic [31:0] dev_oe_n,
  // host side of the data lines
  input  wire logic [31:0] host_data,
  input  wire logic        host_drive,
  output logic      [31:0] bus_val,
  output logic             clash
);
  logic [31:0] last_r;
  // ========
  // released lines show the inverse of the last value, never a stale copy
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      bus_val[i] = !dev_oe_n[i] ? dev_out[i] : (host_drive ? host_data[i] : !last_r[i]);
    end
  end
  always_ff @(posedge mclk) begin
    last_r <= bus_val;
  end
  // host drives only once the memory outputs are off
  assign clash = host_drive && (dev_oe_n != 32'hffffffff);
endmodule // bus_host_model

// *** dv/test_burst_sram_port.sv ***
// self-checking bench for the pipelined burst memory port
`timescale 1ns/1ps
module test_burst_sram_port;
  localparam logic [18:0] BASE = 19'h000a0;
  localparam logic [2:0]  OK   = 3'h2;
  logic        mclk = 1'b0, rst_b = 1'b0, msel_n = 1'b0, ssel_hi = 1'b1, ssel_lo_n = 1'b0;
  logic        pstb_n = 1'b1, cstb_n = 1'b1, fwd_n = 1'b1, gw_n = 1'b1, gate_n = 1'b1;
  logic        oe_n = 1'b1, order = 1'b1, sleep = 1'b0, drv = 1'b0, slp_st, clash;
  logic [3:0]  lane_n = 4'hf;
  logic [18:0] addr = 19'h0;
  logic [31:0] hdat = 32'h0, din, dout, doe_n;
  logic [31:0] mem_m [4];
  int          fail_count = 0, tests_run = 0;

  burst_sram_port u_burst_sram_port (.mclk, .rst_b, .addr, .master_select_n(msel_n),
    .secondary_select_high(ssel_hi), .secondary_select_low_n(ssel_lo_n),
    .proc_addr_strobe_n(pstb_n), .ctrl_addr_strobe_n(cstb_n), .burst_advance_n(fwd_n),
    .global_write_n(gw_n), .byte_write_gate_n(gate_n), .lane_write_n(lane_n),
    .output_enable_n(oe_n), .burst_order_select(order), .sleep_request(sleep),
    .data_in(din), .data_out(dout), .data_oe_n(doe_n), .sleep_state(slp_st));
  bus_host_model u_bus_host_model (.mclk, .dev_out(dout), .dev_oe_n(doe_n),
    .host_data(hdat), .host_drive(drv), .bus_val(din), .clash);

  initial forever #2.5 mclk = ~mclk;
  // ========
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one strobe edge, then back to idle
  task automatic launch(input logic proc, input logic [1:0] lo, input logic [2:0] sel,
                        input logic gw);
    addr = BASE | {17'h0, lo};
    {msel_n, ssel_hi, ssel_lo_n} = sel;
    pstb_n = !proc;
    cstb_n = proc;
    gw_n = gw;
    tick;
    {pstb_n, cstb_n, gw_n, gate_n, drv} = 5'h1e;
    lane_n = 4'hf;
  endtask
  task automatic wr(input logic [1:0] lo, input logic [31:0] d);
    oe_n = 1'b1;
    hdat = d;
    drv = 1'b1;
    launch(1'b0, lo, OK, 1'b0);
    mem_m[lo] = d;
  endtask
  task automatic rd(input logic [1:0] lo);
    oe_n = 1'b0;
    launch(1'b1, lo, OK, 1'b1);
    tick;
    chk("read data", mem_m[lo], dout);
    chk("drive enable", 32'h0, doe_n);
  endtask
  // ========
  task automatic t_basic;
    for (int i = 0; i < 4; i++) wr(i[1:0], 32'h5a00_0000 + i * 32'h0101);
    for (int i = 0; i < 4; i++) rd(i[1:0]);
    oe_n = 1'b1;
    tick;
    chk("drive enable oe off", 32'hffffffff, doe_n);
  endtask
  // lane writes ignored on the processor strobe edge, then a gated write, then no-write
  task automatic t_lanes;
    oe_n = 1'b1;
    {gate_n, lane_n, hdat, drv} = {1'b0, 4'h0, 32'hffffffff, 1'b1};
    launch(1'b1, 2'h1, OK, 1'b1);
    {gate_n, lane_n, hdat, drv} = {1'b0, 4'ha, 32'hc3c3c3c3, 1'b1};
    tick;
    {gate_n, lane_n, hdat} = {1'b1, 4'h0, 32'h0};
    tick;
    chk("bus clash", 32'h0, {31'h0, clash});
    {gate_n, lane_n, drv} = {1'b1, 4'hf, 1'b0};
    mem_m[1] = (mem_m[1] & 32'hff00ff00) | 32'h00c300c3;
    rd(2'h1);
  endtask
  task automatic t_burst;
    logic [1:0] s, e;
    for (int o = 0; o < 2; o++) begin
      order = o[0];
      s = o[0] ? 2'h1 : 2'h3;
      oe_n = 1'b0;
      fwd_n = 1'b0;
      launch(1'b1, s, OK, 1'b1);
      for (int i = 0; i < 4; i++) begin
        tick;
        e = o[0] ? s ^ i[1:0] : s + i[1:0];
        chk("burst data", mem_m[e], dout);
      end
      fwd_n = 1'b1;
    end
  endtask
  task automatic t_deselect;
    logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3};
    for (int i = 0; i < 3; i++) begin
      rd(2'h0);
      launch(1'b0, 2'h2, bad[i], 1'b1);
      tick;
      chk("deselect enable", 32'hffffffff, doe_n);
    end
    rd(2'h0);
    launch(1'b1, 2'h2, 3'h6, 1'b1);
    tick;
    chk("blocked strobe data", mem_m[0], dout);
  endtask
  task automatic t_sleep;
    rd(2'h2);
    sleep = 1'b1;
    tick;
    chk("sleep state", 32'h1, {31'h0, slp_st});
    chk("sleep enable", 32'hffffffff, doe_n);
    hdat = 32'h0bad_0bad;
    drv = 1'b1;
    launch(1'b0, 2'h2, OK, 1'b0);
    sleep = 1'b0;
    tick;
    tick;
    rd(2'h2);
  endtask
  // ========
  initial begin
    repeat (3000) @(posedge mclk);
    fail_count++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge mclk);
    #1;
    chk("reset enable", 32'hffffffff, doe_n);
    rst_b = 1'b1;
    tick;
    t_basic;
    t_lanes;
    t_burst;
    t_deselect;
    t_sleep;
    stop_test;
  end
endmodule // test_burst_sram_port
